/* File: pkg/scs_pkg.sv */
// Package with register map, field positions and reset values for the system configuration bank.
package scs_pkg;
   // Register word addresses (address bit 0 is not decoded).
   localparam logic [15:0] SYSTEM_CONTROL_ADDR         = 16'h7018;
   localparam logic [15:0] SYSTEM_STATUS_ADDR          = 16'h701a;
   localparam logic [15:0] INTERRUPT_VECTOR_LATCH_ADDR = 16'h701e;
   // Control register fields.
   localparam int SOFT_RESET_HIGH_BIT_POS   = 15;
   localparam int SOFT_RESET_LOW_BIT_POS    = 14;
   localparam int CLOCK_OUT_SELECT_HIGH_POS = 7;
   localparam int CLOCK_OUT_SELECT_LOW_POS  = 6;
   // Status register fields.
   localparam int POWER_ON_RESET_FLAG_POS      = 15;
   localparam int BAD_ADDRESS_RESET_FLAG_POS   = 12;
   localparam int SOFT_RESET_FLAG_POS          = 10;
   localparam int WATCHDOG_RESET_FLAG_POS      = 9;
   localparam int PROTECT_OVERRIDE_FLAG_POS    = 5;
   localparam int ANALOG_SUPPLY_FAULT_FLAG_POS = 3;
   localparam int VECTOR_READ_PENDING_POS      = 0;
   // Reset values.
   localparam logic [1:0] SOFT_RESET_BITS_RESET  = 2'h1;
   localparam logic [1:0] CLOCK_OUT_SELECT_POR   = 2'h3;
   localparam logic       ANALOG_FAULT_RESET     = 1'h1;
   // Cause flags after power-up, ordered power-on, bad address, software, watchdog.
   localparam logic [3:0] CAUSE_FLAGS_POR        = 4'h8;
   // Value returned in reserved bit positions.
   localparam logic [15:0] RESERVED_READ_VALUE   = 16'h0000;
   // Clock output source codes.
   typedef enum logic [1:0] {
      SCS_CLKO_DIGITAL_IO = 2'h0,
      SCS_CLKO_WATCHDOG   = 2'h1,
      SCS_CLKO_SYSTEM     = 2'h2,
      SCS_CLKO_CORE       = 2'h3
   } scs_clock_out_type;
endpackage : scs_pkg

/* File: rtl/scs_clock_out_mux.sv */
// Clock output pin source selector.
`timescale 1ns/1ns
module scs_clock_out_mux (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic [1:0] i_select,
   input  wire logic       i_digital_io,
   input  wire logic       i_watchdog_clock,
   input  wire logic       i_system_clock,
   input  wire logic       i_core_clock,
   output logic            o_clock_output_pin
);
   logic out_d;
   logic out_q;

   // Select the pin source; the result is registered so the pin is glitch free.
   always_comb begin
      case (scs_pkg::scs_clock_out_type'(i_select))
         scs_pkg::SCS_CLKO_DIGITAL_IO: out_d = i_digital_io;
         scs_pkg::SCS_CLKO_WATCHDOG:   out_d = i_watchdog_clock;
         scs_pkg::SCS_CLKO_SYSTEM:     out_d = i_system_clock;
         scs_pkg::SCS_CLKO_CORE:       out_d = i_core_clock;
         default:                      out_d = i_digital_io;
      endcase
   end

   // Output register.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         out_q <= 1'h0;
      end else begin
         out_q <= out_d;
      end
   end

   assign o_clock_output_pin = out_q;

   property p_mux_core;
      @(posedge i_clk) disable iff (i_reset)
      (i_select == 2'h3) |=> (o_clock_output_pin == $past(i_core_clock));
   endproperty
   a_mux_core: assert property (p_mux_core) else $error("clock out not core clock");
endmodule : scs_clock_out_mux

/* File: rtl/scs_protect_override.sv */
// Protect-override flag tracking the flash programming voltage pin.
`timescale 1ns/1ns
module scs_protect_override (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_reset_pin_release,
   input  wire logic i_flash_program_voltage_pin,
   input  wire logic i_clear,
   output logic      o_protect_override_flag
);
   logic flag_d;
   logic flag_q;

   // Set on reset release with the pin high; cleared when the pin drops or software clears.
   // The set at reset release wins over a software clear in the same cycle.
   always_comb begin
      flag_d = flag_q;
      if (i_clear) begin
         flag_d = 1'h0;
      end
      if (!i_flash_program_voltage_pin) begin
         flag_d = 1'h0;
      end else if (i_reset_pin_release) begin
         flag_d = 1'h1;
      end
   end

   // Flag register.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         flag_q <= 1'h0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign o_protect_override_flag = flag_q;

   property p_po_drop;
      @(posedge i_clk) disable iff (i_reset)
      !i_flash_program_voltage_pin |=> !o_protect_override_flag;
   endproperty
   a_po_drop: assert property (p_po_drop) else $error("override kept without voltage");
endmodule : scs_protect_override

/* File: rtl/scs_system_config.sv */
// System configuration and status register bank on the peripheral bus.
// Function
// - Address bit 0 ignored; each register answers at even and odd address.
// - Reserved bits read undefined (zero here); writing them changes nothing.
// - Control write starts global reset unless bits 15,14 are 0,1.
// - Soft reset bits reset to 0,1; clock select kept, set by power-on.
// - Clock output source: I/O, watchdog clock, system clock, core clock.
// - Power-on reset from detector or pin sets status bit 15.
// - Unimplemented-address access causes reset and sets status bit 12.
// - Software reset through control bits sets status bit 10.
// - Watchdog overflow reset sets status bit 9.
// - Reset-cause bits readable, clear-only, kept through ordinary reset.
// - Protect override set at reset release with pin high, cleared otherwise.
// - Protect override enables flash programming and watchdog disable.
// - Status bit 3 shows analog supply fault, resets to 1.
// - Status bit 0 set on vector latch, cleared by vector read.
// - Vector register low byte holds offset, high byte reads zero.
`timescale 1ns/1ns
module scs_system_config (
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic        i_power_on_reset,
   input  wire logic        i_low_voltage_detect,
   input  wire logic        i_bad_address,
   input  wire logic        i_watchdog_overflow,
   input  wire logic        i_reset_pin_release,
   input  wire logic        i_flash_program_voltage_pin,
   input  wire logic        i_analog_supply_ok,
   input  wire logic        i_vector_ack,
   input  wire logic [7:0]  i_vector_offset,
   input  wire logic        i_watchdog_disable_bit,
   input  wire logic        i_digital_io,
   input  wire logic        i_watchdog_clock,
   input  wire logic        i_system_clock,
   input  wire logic        i_core_clock,
   input  wire logic        i_bus_read,
   input  wire logic        i_bus_write,
   input  wire logic [15:0] i_bus_addr,
   input  wire logic [15:0] i_bus_wdata,
   output logic [15:0]      o_bus_rdata,
   output logic             o_bus_hit,
   output logic             o_global_reset,
   output logic             o_clock_output_pin,
   output logic             o_flash_program_enable,
   output logic             o_watchdog_disable
);
   ////////////////////////////////////////////////////////////////////////////////
   // Address decode.
   logic [14:0] word_addr;
   logic        sel_ctrl;
   logic        sel_stat;
   logic        sel_vec;

   // Decode ignores bit 0 so the odd neighbour reaches the same register.
   function automatic logic addr_match(input logic [14:0] a, input logic [15:0] reg_addr);
      addr_match = (a == reg_addr[15:1]);
   endfunction : addr_match

   assign word_addr = i_bus_addr[15:1];
   assign sel_ctrl  = addr_match(word_addr, scs_pkg::SYSTEM_CONTROL_ADDR);
   assign sel_stat  = addr_match(word_addr, scs_pkg::SYSTEM_STATUS_ADDR);
   assign sel_vec   = addr_match(word_addr, scs_pkg::INTERRUPT_VECTOR_LATCH_ADDR);
   assign o_bus_hit = sel_ctrl | sel_stat | sel_vec;

   ////////////////////////////////////////////////////////////////////////////////
   // Control register.
   logic [1:0] soft_reset_d;
   logic [1:0] soft_reset_q;
   logic [1:0] clock_sel_d;
   logic [1:0] clock_sel_q;
   logic       wr_ctrl;
   logic       soft_reset_trigger;
   logic       any_reset_q;
   logic       any_reset_d;

   assign wr_ctrl = i_bus_write & sel_ctrl;
   // Only the 0,1 pattern is harmless; both bits are taken from one write.
   assign soft_reset_trigger = wr_ctrl &
      !(!i_bus_wdata[scs_pkg::SOFT_RESET_HIGH_BIT_POS] & i_bus_wdata[scs_pkg::SOFT_RESET_LOW_BIT_POS]);

   // Soft reset bits return to their idle pattern whenever the chip resets.
   always_comb begin
      soft_reset_d = soft_reset_q;
      if (wr_ctrl) begin
         soft_reset_d = {i_bus_wdata[scs_pkg::SOFT_RESET_HIGH_BIT_POS],
                         i_bus_wdata[scs_pkg::SOFT_RESET_LOW_BIT_POS]};
      end
      if (any_reset_q) begin
         soft_reset_d = scs_pkg::SOFT_RESET_BITS_RESET;
      end
   end

   // Clock select only reacts to writes; power-on is the asynchronous reset.
   always_comb begin
      clock_sel_d = clock_sel_q;
      if (wr_ctrl) begin
         clock_sel_d = {i_bus_wdata[scs_pkg::CLOCK_OUT_SELECT_HIGH_POS],
                        i_bus_wdata[scs_pkg::CLOCK_OUT_SELECT_LOW_POS]};
      end
   end

   // The global reset pulse is registered so it never loops back combinationally.
   assign any_reset_d = soft_reset_trigger | i_bad_address | i_watchdog_overflow;

   // i_reset is power-on reset; ordinary resets are o_global_reset and only return the soft reset bits to 0,1.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         soft_reset_q <= scs_pkg::SOFT_RESET_BITS_RESET;
         clock_sel_q  <= scs_pkg::CLOCK_OUT_SELECT_POR;
         any_reset_q  <= 1'h0;
      end else begin
         soft_reset_q <= soft_reset_d;
         clock_sel_q  <= clock_sel_d;
         any_reset_q  <= any_reset_d;
      end
   end

   assign o_global_reset = any_reset_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset cause flags: bit order power-on, bad address, software, watchdog.
   logic [3:0] cause_d;
   logic [3:0] cause_q;
   logic [3:0] cause_set;
   logic [3:0] cause_clr;
   logic       wr_stat;

   assign wr_stat   = i_bus_write & sel_stat;
   assign cause_set = {i_power_on_reset | i_low_voltage_detect,
                       i_bad_address,
                       soft_reset_trigger,
                       i_watchdog_overflow};
   assign cause_clr = wr_stat ? {i_bus_wdata[scs_pkg::POWER_ON_RESET_FLAG_POS],
                                 i_bus_wdata[scs_pkg::BAD_ADDRESS_RESET_FLAG_POS],
                                 i_bus_wdata[scs_pkg::SOFT_RESET_FLAG_POS],
                                 i_bus_wdata[scs_pkg::WATCHDOG_RESET_FLAG_POS]} : 4'h0;

   // Write one clears; a simultaneous hardware event wins so no cause is lost.
   always_comb begin
      cause_d = (cause_q & ~cause_clr) | cause_set;
   end

   // Power-up is itself a power-on reset, so it leaves only the power-on cause standing.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cause_q <= scs_pkg::CAUSE_FLAGS_POR;
      end else begin
         cause_q <= cause_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Protect override, analog fault and vector latch.
   logic       protect_override;
   logic       analog_fault_q;
   logic       analog_fault_d;
   logic [7:0] vector_d;
   logic [7:0] vector_q;
   logic       vec_pending_d;
   logic       vec_pending_q;
   logic       rd_vec;

   scs_protect_override u_protect (
      .i_clk                       (i_clk),
      .i_reset                     (i_reset),
      .i_reset_pin_release         (i_reset_pin_release),
      .i_flash_program_voltage_pin (i_flash_program_voltage_pin),
      .i_clear                     (wr_stat & i_bus_wdata[scs_pkg::PROTECT_OVERRIDE_FLAG_POS]),
      .o_protect_override_flag     (protect_override)
   );

   assign o_flash_program_enable = protect_override;
   assign o_watchdog_disable     = protect_override & i_watchdog_disable_bit;

   assign rd_vec = i_bus_read & sel_vec;

   // Pending flag: a new latch in the same cycle as a read keeps the flag set.
   always_comb begin
      analog_fault_d = !i_analog_supply_ok;
      vector_d       = i_vector_ack ? i_vector_offset : vector_q;
      vec_pending_d  = vec_pending_q;
      if (rd_vec) begin
         vec_pending_d = 1'h0;
      end
      if (i_vector_ack) begin
         vec_pending_d = 1'h1;
      end
   end

   // Status and vector registers.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         analog_fault_q <= scs_pkg::ANALOG_FAULT_RESET;
         vector_q       <= 8'h00;
         vec_pending_q  <= 1'h0;
      end else begin
         analog_fault_q <= analog_fault_d;
         vector_q       <= vector_d;
         vec_pending_q  <= vec_pending_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clock output selection.
   scs_clock_out_mux u_clock_out (
      .i_clk              (i_clk),
      .i_reset            (i_reset),
      .i_select           (clock_sel_q),
      .i_digital_io       (i_digital_io),
      .i_watchdog_clock   (i_watchdog_clock),
      .i_system_clock     (i_system_clock),
      .i_core_clock       (i_core_clock),
      .o_clock_output_pin (o_clock_output_pin)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read data; reserved positions return a fixed pattern.
   logic [15:0] rdata_d;
   logic [15:0] rdata_q;

   always_comb begin
      rdata_d = scs_pkg::RESERVED_READ_VALUE;
      if (i_bus_read && sel_ctrl) begin
         rdata_d[scs_pkg::SOFT_RESET_HIGH_BIT_POS]   = soft_reset_q[1];
         rdata_d[scs_pkg::SOFT_RESET_LOW_BIT_POS]    = soft_reset_q[0];
         rdata_d[scs_pkg::CLOCK_OUT_SELECT_HIGH_POS] = clock_sel_q[1];
         rdata_d[scs_pkg::CLOCK_OUT_SELECT_LOW_POS]  = clock_sel_q[0];
      end else if (i_bus_read && sel_stat) begin
         rdata_d[scs_pkg::POWER_ON_RESET_FLAG_POS]      = cause_q[3];
         rdata_d[scs_pkg::BAD_ADDRESS_RESET_FLAG_POS]   = cause_q[2];
         rdata_d[scs_pkg::SOFT_RESET_FLAG_POS]          = cause_q[1];
         rdata_d[scs_pkg::WATCHDOG_RESET_FLAG_POS]      = cause_q[0];
         rdata_d[scs_pkg::PROTECT_OVERRIDE_FLAG_POS]    = protect_override;
         rdata_d[scs_pkg::ANALOG_SUPPLY_FAULT_FLAG_POS] = analog_fault_q;
         rdata_d[scs_pkg::VECTOR_READ_PENDING_POS]      = vec_pending_q;
      end else if (i_bus_read && sel_vec) begin
         rdata_d = {8'h00, vector_q};
      end
   end

   // Read data register; holds zero outside read cycles.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign o_bus_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   property p_odd_alias;
      @(posedge i_clk) disable iff (i_reset)
      (i_bus_addr == 16'h701f) |-> sel_vec;
   endproperty
   a_odd_alias: assert property (p_odd_alias) else $error("odd address not aliased");

   property p_safe_pattern;
      @(posedge i_clk) disable iff (i_reset)
      (wr_ctrl && i_bus_wdata[15:14] == 2'h1 && !i_bad_address && !i_watchdog_overflow) |=> !o_global_reset;
   endproperty
   a_safe_pattern: assert property (p_safe_pattern) else $error("reset on harmless pattern");

   property p_reset_pattern;
      @(posedge i_clk) disable iff (i_reset)
      (wr_ctrl && i_bus_wdata[15:14] != 2'h1) |=> (o_global_reset && cause_q[1]);
   endproperty
   a_reset_pattern: assert property (p_reset_pattern) else $error("software reset missed");

   property p_por_flag;
      @(posedge i_clk) disable iff (i_reset)
      i_power_on_reset |=> cause_q[3];
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("power-on flag not set");

   property p_bad_addr;
      @(posedge i_clk) disable iff (i_reset)
      i_bad_address |=> (cause_q[2] && o_global_reset);
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("bad address not recorded");

   property p_wd_flag;
      @(posedge i_clk) disable iff (i_reset)
      i_watchdog_overflow |=> cause_q[0];
   endproperty
   a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag not set");

   property p_cause_hold;
      @(posedge i_clk) disable iff (i_reset)
      (!wr_stat && cause_set == 4'h0) |=> (cause_q == $past(cause_q));
   endproperty
   a_cause_hold: assert property (p_cause_hold) else $error("cause flags changed unasked");

   property p_clksel_kept;
      @(posedge i_clk) disable iff (i_reset)
      (!wr_ctrl && o_global_reset) |=> (clock_sel_q == $past(clock_sel_q));
   endproperty
   a_clksel_kept: assert property (p_clksel_kept) else $error("clock select lost on reset");

   property p_vec_pending;
      @(posedge i_clk) disable iff (i_reset)
      i_vector_ack |=> (vec_pending_q && vector_q == $past(i_vector_offset));
   endproperty
   a_vec_pending: assert property (p_vec_pending) else $error("vector not latched");

   property p_vec_read;
      @(posedge i_clk) disable iff (i_reset)
      (rd_vec && !i_vector_ack) |=> (!vec_pending_q && o_bus_rdata[15:8] == 8'h00);
   endproperty
   a_vec_read: assert property (p_vec_read) else $error("vector read did not clear");

   property p_analog;
      @(posedge i_clk) disable iff (i_reset)
      !i_analog_supply_ok |=> analog_fault_q;
   endproperty
   a_analog: assert property (p_analog) else $error("analog fault not shown");

   property p_wd_disable;
      @(posedge i_clk) disable iff (i_reset)
      !protect_override |-> !o_watchdog_disable;
   endproperty
   a_wd_disable: assert property (p_wd_disable) else $error("watchdog disable without override");
endmodule : scs_system_config

/* File: verification/scs_cpu_model.sv */
// CPU side model that issues peripheral bus reads and writes.
`timescale 1ns/1ns
module scs_cpu_model (
   input  wire logic        i_clk,
   input  wire logic [15:0] i_bus_rdata,
   output logic             o_bus_read,
   output logic             o_bus_write,
   output logic [15:0]      o_bus_addr,
   output logic [15:0]      o_bus_wdata
);
   //////////////////////////////
   // Bus lines start idle.
   initial begin
      o_bus_read  = 1'b0;
      o_bus_write = 1'b0;
      o_bus_addr  = 16'h0000;
      o_bus_wdata = 16'h0000;
   end
   // A released bus shows inverted values, so a stale address can never pass for a held one.
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clk);
      o_bus_write <= 1'b1;
      o_bus_addr  <= a;
      o_bus_wdata <= d;
      @(posedge i_clk);
      o_bus_write <= 1'b0;
      o_bus_addr  <= ~a;
      o_bus_wdata <= ~d;
   endtask : wr
   // Read data is taken in the cycle after the strobe is accepted.
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge i_clk);
      o_bus_read <= 1'b1;
      o_bus_addr <= a;
      @(posedge i_clk);
      o_bus_read <= 1'b0;
      o_bus_addr <= ~a;
      @(negedge i_clk);
      d = i_bus_rdata;
   endtask : rd
endmodule : scs_cpu_model

/* File: verification/testbench.sv */
// Self-checking bench for the system configuration bank.
`timescale 1ns/1ns
module testbench;
   typedef struct {logic wr; logic [15:0] addr; logic [15:0] data;} scs_row_type;
   logic        i_clk, i_reset, vpp, wdd, aok, rd_s, wr_s, fl, wd;
   logic [5:0]  evt;
   logic [3:0]  src;
   logic [7:0]  voff;
   logic [15:0] addr, wdat, rdata, rdat;
   logic        greset, pin, hit, hit_q;
   int          n_fail, comparisons, n_greset, g0;
   scs_row_type rows [10] = '{'{0, 16'h7018, 16'h40c0}, '{0, 16'h7019, 16'h40c0}, '{0, 16'h701a, 16'h8008},
      '{0, 16'h701f, 16'h0000}, '{0, 16'h7000, 16'h0000}, '{1, 16'h7019, 16'h7f00}, '{0, 16'h7018, 16'h4000},
      '{1, 16'h7018, 16'h40bf}, '{0, 16'h7019, 16'h4080}, '{1, 16'h701a, 16'hffff}};
   logic [15:0] emask [4] = '{16'h8000, 16'h8000, 16'h1000, 16'h0200};
   logic [1:0]  pats [3] = '{2'h0, 2'h2, 2'h3};
   //////////////////////////////
   scs_system_config dut (.i_clk(i_clk), .i_reset(i_reset), .i_power_on_reset(evt[0]),
      .i_low_voltage_detect(evt[1]), .i_bad_address(evt[2]), .i_watchdog_overflow(evt[3]),
      .i_reset_pin_release(evt[4]), .i_flash_program_voltage_pin(vpp), .i_analog_supply_ok(aok),
      .i_vector_ack(evt[5]), .i_vector_offset(voff), .i_watchdog_disable_bit(wdd),
      .i_digital_io(src[0]), .i_watchdog_clock(src[1]), .i_system_clock(src[2]), .i_core_clock(src[3]),
      .i_bus_read(rd_s), .i_bus_write(wr_s), .i_bus_addr(addr), .i_bus_wdata(wdat), .o_bus_rdata(rdata),
      .o_bus_hit(hit), .o_global_reset(greset), .o_clock_output_pin(pin), .o_flash_program_enable(fl),
      .o_watchdog_disable(wd));
   scs_cpu_model cpu (.i_clk(i_clk), .i_bus_rdata(rdata), .o_bus_read(rd_s), .o_bus_write(wr_s),
      .o_bus_addr(addr), .o_bus_wdata(wdat));
   //////////////////////////////
   // Clock at 125 MHz.
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // Each global reset pulse lasts one cycle, so counting high cycles counts pulses.
   always @(posedge i_clk) if (greset === 1'b1) n_greset++;
   // Keep the decode flag seen at the edge that takes each access.
   always @(posedge i_clk) if (rd_s === 1'b1 || wr_s === 1'b1) hit_q <= hit;
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask : wait_cyc
   task automatic pulse(input logic [5:0] m);
      @(posedge i_clk) evt <= m;
      @(posedge i_clk) evt <= 6'h00;
      wait_cyc(2);
   endtask : pulse
   task automatic st(input logic [15:0] exp);
      cpu.rd(16'h701a, rdat);
      chk("status", rdat, exp);
   endtask : st
   task automatic tally_and_finish;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   // A hang is cut short well after the expected run of about 230 cycles.
   initial begin
      #160000;
      n_fail++;
      tally_and_finish();
   end
   //////////////////////////////
   // Main sequence: table rows first, then the awkward cases.
   initial begin
      {i_reset, vpp, wdd, aok, evt, src, voff} = '0;
      i_reset = 1'b1;
      repeat (10) @(posedge i_clk);
      i_reset <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr) cpu.wr(rows[i].addr, rows[i].data);
         else cpu.rd(rows[i].addr, rdat);
         if (!rows[i].wr) chk("table", rdat, rows[i].data);
         wait_cyc(0);
         chk("hit", {15'h0, hit_q}, {15'h0, rows[i].addr != 16'h7000});
      end
      chk("no_greset", 16'(n_greset), 16'h0000);
      for (int s = 0; s < 8; s++) begin
         if (s[0] == 1'b0) cpu.wr(16'h7018, {8'h40, s[2:1], 6'h00});
         @(posedge i_clk) src <= s[0] ? ~(4'h1 << s[2:1]) : (4'h1 << s[2:1]);
         wait_cyc(3);
         chk("clock_pin", {15'h0, pin}, {15'h0, ~s[0]});
      end
      foreach (pats[i]) begin
         g0 = n_greset;
         cpu.wr(16'h7018, {pats[i], 6'h00, 2'h1, 6'h00});
         wait_cyc(3);
         chk("greset_count", 16'(n_greset - g0), 16'h0001);
         cpu.rd(16'h7018, rdat);
         chk("control_kept", rdat, 16'h4040);
         cpu.wr(16'h701a, 16'h0000);
         st(16'h0408);
         cpu.wr(16'h701a, 16'h0400);
         st(16'h0008);
      end
      for (int e = 0; e < 4; e++) begin
         g0 = n_greset;
         pulse(6'h01 << e);
         st(emask[e] | 16'h0008);
         chk("cause_greset", 16'(n_greset - g0), {15'h0, e[1]});
         cpu.wr(16'h701a, emask[e]);
         st(16'h0008);
      end
      // Hardware set and software clear land on the same edge.
      fork
         cpu.wr(16'h701a, 16'h0200);
         pulse(6'h08);
      join
      st(16'h0208);
      cpu.wr(16'h701a, 16'h0200);
      voff <= 8'ha5;
      pulse(6'h20);
      st(16'h0009);
      cpu.rd(16'h701f, rdat);
      chk("vector", rdat, 16'h00a5);
      st(16'h0008);
      @(posedge i_clk) voff <= 8'h3c;
      fork
         cpu.rd(16'h701e, rdat);
         pulse(6'h20);
      join
      st(16'h0009);
      cpu.rd(16'h701e, rdat);
      chk("vector2", rdat, 16'h003c);
      @(posedge i_clk) {vpp, wdd} <= 2'h3;
      pulse(6'h10);
      st(16'h0028);
      chk("override", {14'h0, fl, wd}, 16'h0003);
      @(posedge i_clk) wdd <= 1'b0;
      wait_cyc(1);
      chk("override_wd", {14'h0, fl, wd}, 16'h0002);
      @(posedge i_clk) vpp <= 1'b0;
      wait_cyc(2);
      st(16'h0008);
      chk("override_off", {14'h0, fl, wd}, 16'h0000);
      @(posedge i_clk) vpp <= 1'b1;
      wait_cyc(2);
      st(16'h0008);
      pulse(6'h10);
      cpu.wr(16'h701a, 16'h0020);
      st(16'h0008);
      @(posedge i_clk) aok <= 1'b1;
      wait_cyc(3);
      st(16'h0000);
      @(posedge i_clk) i_reset <= 1'b1;
      @(posedge i_clk) i_reset <= 1'b0;
      cpu.rd(16'h7018, rdat);
      chk("por_control", rdat, 16'h40c0);
      st(16'h8000);
      tally_and_finish();
   end
endmodule : testbench
